/* src/gpmx_external_irq_line_filter.sv */
// One external interrupt line: glitch filter and trigger-mode detector.
`timescale 1ns/1ps
`default_nettype none

module gpmx_external_irq_line_filter (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       en_in,
  input  wire logic       level_in,
  input  wire logic [2:0] mode_in,
  output logic            event_out
);

  logic [1:0] cnt_reg;
  logic       filt_reg;
  logic       prev_reg;
  logic       diff;
  logic       take;
  logic       rose;
  logic       fell;

  assign diff = level_in != filt_reg;
  assign take = diff && (cnt_reg == gpmx_pkg::FILT_CLKS);
  assign rose = filt_reg && !prev_reg;
  assign fell = !filt_reg && prev_reg;

  // While disabled the filter tracks the pin so enabling makes no false edge.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg  <= 2'h0;
      filt_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      cnt_reg  <= (diff && en_in && !take) ? cnt_reg + 2'h1 : 2'h0;
      filt_reg <= (!en_in || take) ? level_in : filt_reg;
      prev_reg <= en_in ? filt_reg : level_in;
    end
  end

  assign event_out = en_in && (
      (mode_in == gpmx_pkg::TRIG_LOW  && !filt_reg) ||
      (mode_in == gpmx_pkg::TRIG_HIGH &&  filt_reg) ||
      (mode_in[2:1] == gpmx_pkg::TRIG_FALL && fell) ||
      (mode_in[2:1] == gpmx_pkg::TRIG_RISE && rose) ||
      (mode_in[2:1] == gpmx_pkg::TRIG_BOTH && (rose || fell)));

  a_filter_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    en_in && $past(en_in) && $changed(filt_reg) |->
      $past(diff, 1) && $past(diff, 2) && $past(diff, 3) && $past(diff, 4))
    else $error("Filtered level changed after a pulse of three clocks or less.");

  a_rise_event: assert property (@(posedge clk_in) disable iff (rst_in)
    en_in && $past(en_in) && mode_in[2:1] == gpmx_pkg::TRIG_RISE && $rose(filt_reg) |->
      event_out)
    else $error("Rising edge missed in rising-edge mode.");

endmodule // gpmx_external_irq_line_filter

`default_nettype wire

/* src/gpmx_pkg.sv */
// Package of constants and carrier types for the pin mux and external interrupt block.
package gpmx_pkg;

  localparam int NPORT   = 5;
  localparam int PIN_W   = 16;
  localparam int NLINE   = 24;
  localparam int NPIN    = NPORT * PIN_W;

  // Port order: 0 = D, 1 = F, 2 = G, 3 = H, 4 = J.
  localparam logic [NPORT-1:0][PIN_W-1:0] PIN_PRESENT  = {16'h1FFF, 16'h07FF, 16'hFFFF,
                                                          16'h00FF, 16'hFFFF};
  localparam logic [NPORT-1:0][PIN_W-1:0] ALT2_PRESENT = {16'h0000, 16'h00C0, 16'h0EFC,
                                                          16'h0000, 16'hC700};
  localparam int PORT_F = 1;
  localparam int PORT_G = 2;
  localparam int LINES_ON_F = 8;
  localparam int WAKE_LINES = 16;

  // Function-select codes.
  localparam logic [1:0] FN_IN   = 2'b00;
  localparam logic [1:0] FN_OUT  = 2'b01;
  localparam logic [1:0] FN_ALT1 = 2'b10;
  localparam logic [1:0] FN_ALT2 = 2'b11;

  // Register map: per-port block, then shared registers.
  localparam logic [2:0] LAST_PORT_BLOCK = 3'h4;
  localparam logic [3:0] SUB_CON   = 4'h0;
  localparam logic [3:0] SUB_DAT   = 4'h4;
  localparam logic [3:0] SUB_PUD   = 4'h8;
  localparam logic [7:0] OFF_MISC  = 8'h50;
  localparam logic [7:0] OFF_TRIG0 = 8'h54;
  localparam logic [7:0] OFF_TRIG1 = 8'h58;
  localparam logic [7:0] OFF_TRIG2 = 8'h5C;
  localparam logic [7:0] OFF_STAT  = 8'h60;
  localparam logic [7:0] OFF_CLR   = 8'h64;
  localparam logic [7:0] OFF_EN    = 8'h68;

  // Reset values.
  localparam logic [31:0] CON_RST  = 32'h0000_0000;
  localparam logic [15:0] DAT_RST  = 16'h0000;
  localparam logic [15:0] PUD_RST  = 16'h0000;
  localparam logic [31:0] MISC_RST = 32'h0000_0000;
  localparam logic [31:0] TRIG_RST = 32'h0000_0000;
  localparam logic [23:0] EN_RST   = 24'h00_0000;

  // Miscellaneous control field positions.
  localparam int MISC_SLEEP_PUD = 0;
  localparam int MISC_USB_PAD   = 3;
  localparam int MISC_CLOCK_OUTPUT_PIN   = 4;
  localparam int MISC_CLKOUT1   = 8;
  localparam int CLKSEL_W       = 3;

  // Trigger config: eight lines per register, four bits per line, low three used.
  localparam int TRIG_FIELD_W   = 4;
  localparam int LINES_PER_TRIG = 8;
  localparam logic [2:0] TRIG_LOW  = 3'b000;
  localparam logic [2:0] TRIG_HIGH = 3'b001;
  localparam logic [1:0] TRIG_FALL = 2'b01;
  localparam logic [1:0] TRIG_RISE = 2'b10;
  localparam logic [1:0] TRIG_BOTH = 2'b11;

  // Filter passes a change once it has held for more than this many clocks.
  localparam logic [1:0] FILT_CLKS = 2'h3;

  typedef struct packed {
    logic [PIN_W-1:0] en;
    logic [PIN_W-1:0] level;
  } gpmx_drive_s;

  typedef struct packed {
    logic                sleep_data_pud_dis;
    logic                usb_pad_host;
    logic [CLKSEL_W-1:0] clock_output_pin_sel;
    logic [CLKSEL_W-1:0] clkout1_sel;
  } gpmx_misc_s;

endpackage

/* src/gpmx_top.sv */
// Pin function mux, port data and pull-up registers, and external interrupt lines.
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Route each pin per its function field.
// - Codes 00 input, 01 output, 10/11 alternates.
// - Output pins drive their data register bit.
// - Input pins read back live pin level.
// - Pull-up bit 0 enables, 1 disables.
// - Pull-up independent of selected pin function.
// - Misc register: sleep pull-ups, USB pad, clock-out.
// - 24 lines: low, high, fall, rise, both.
// - Filter accepts pulses longer than 3 clocks.
// - Lines 0 to 15 are wakeup sources.
module gpmx_top (
  input  wire logic                                        clk_in,
  input  wire logic                                        rst_in,
  input  wire logic [7:0]                                  addr_in,
  input  wire logic [31:0]                                 wdata_in,
  input  wire logic                                        wr_in,
  input  wire logic                                        rd_in,
  output logic      [31:0]                                 rdata_out,
  input  wire logic [gpmx_pkg::NPORT-1:0][gpmx_pkg::PIN_W-1:0] pin_in,
  output logic      [gpmx_pkg::NPORT-1:0][gpmx_pkg::PIN_W-1:0] pin_out,
  output logic      [gpmx_pkg::NPORT-1:0][gpmx_pkg::PIN_W-1:0] pin_oe_n_out,
  output logic      [gpmx_pkg::NPORT-1:0][gpmx_pkg::PIN_W-1:0] pull_up_en_out,
  input  wire gpmx_pkg::gpmx_drive_s [gpmx_pkg::NPORT-1:0]    alt1_in,
  input  wire gpmx_pkg::gpmx_drive_s [gpmx_pkg::NPORT-1:0]    alt2_in,
  output logic      [gpmx_pkg::NPORT-1:0][gpmx_pkg::PIN_W-1:0] pin_level_out,
  output gpmx_pkg::gpmx_misc_s                             misc_out,
  output logic                                             irq_out,
  output logic                                             wake_out
);

  localparam int NP = gpmx_pkg::NPORT;
  localparam int PW = gpmx_pkg::PIN_W;
  localparam int NL = gpmx_pkg::NLINE;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and synchronisers.

  logic [NP-1:0][31:0]   con_reg;
  logic [NP-1:0][PW-1:0] dat_reg;
  logic [NP-1:0][PW-1:0] pud_reg;
  logic [NP-1:0][PW-1:0] sync1_reg;
  logic [NP-1:0][PW-1:0] sync2_reg;
  logic [31:0]           misc_reg;
  logic [2:0][31:0]      trig_reg;
  logic [NL-1:0]         stat_reg;
  logic [NL-1:0]         stat_next;
  logic [NL-1:0]         en_reg;
  logic [31:0]           rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic [2:0]  port_sel;
  logic [3:0]  sub_sel;
  logic        port_hit;
  logic [NP-1:0] wr_con;
  logic [NP-1:0] wr_dat;
  logic [NP-1:0] wr_pud;
  logic        wr_misc;
  logic [2:0]  wr_trig;
  logic        wr_clr;
  logic        wr_en;

  assign port_sel = addr_in[6:4];
  assign sub_sel  = addr_in[3:0];
  assign port_hit = !addr_in[7] && (port_sel <= gpmx_pkg::LAST_PORT_BLOCK);
  assign wr_misc  = wr_in && addr_in == gpmx_pkg::OFF_MISC;
  assign wr_trig  = {wr_in && addr_in == gpmx_pkg::OFF_TRIG2,
                     wr_in && addr_in == gpmx_pkg::OFF_TRIG1,
                     wr_in && addr_in == gpmx_pkg::OFF_TRIG0};
  assign wr_clr   = wr_in && addr_in == gpmx_pkg::OFF_CLR;
  assign wr_en    = wr_in && addr_in == gpmx_pkg::OFF_EN;

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin function mux.

  logic [NP-1:0][PW-1:0] drv_en;
  logic [NP-1:0][PW-1:0] drv_val;
  logic [NP-1:0][PW-1:0] in_mask;
  logic [NP-1:0][PW-1:0] out_mask;
  logic [NP-1:0][PW-1:0] rsv_mask;
  logic [NP-1:0][PW-1:0] port_rd;
  logic [NP-1:0][PW-1:0] irq_alt_mask;

  genvar gk;
  generate
    for (gk = 0; gk < NP * PW; gk++) begin : g_pin
      localparam int P = gk / PW;
      localparam int B = gk % PW;
      localparam bit IRQ_PIN = (P == gpmx_pkg::PORT_F) || (P == gpmx_pkg::PORT_G);
      logic [1:0] fn;
      logic       here;
      logic       alt2_ok;
      assign fn      = con_reg[P][2*B +: 2];
      assign here    = gpmx_pkg::PIN_PRESENT[P][B];
      assign alt2_ok = gpmx_pkg::ALT2_PRESENT[P][B];
      assign in_mask[P][B]  = here && fn == gpmx_pkg::FN_IN;
      assign out_mask[P][B] = here && fn == gpmx_pkg::FN_OUT;
      assign rsv_mask[P][B] = here && fn == gpmx_pkg::FN_ALT2 && !alt2_ok;
      // Port F and G pins in the first alternate (interrupt) function are inputs only, whatever the peripheral asks.
      assign irq_alt_mask[P][B] = here && IRQ_PIN && fn == gpmx_pkg::FN_ALT1;
      assign drv_en[P][B] = here && ((fn == gpmx_pkg::FN_OUT) ||
          (fn == gpmx_pkg::FN_ALT1 && !IRQ_PIN && alt1_in[P].en[B]) ||
          (fn == gpmx_pkg::FN_ALT2 && alt2_ok && alt2_in[P].en[B]));
      assign drv_val[P][B] = (fn == gpmx_pkg::FN_OUT)  ? dat_reg[P][B] :
                             (fn == gpmx_pkg::FN_ALT1) ? alt1_in[P].level[B] :
                                                         alt2_in[P].level[B];
      assign port_rd[P][B] = in_mask[P][B] ? sync2_reg[P][B] : dat_reg[P][B];
      assign pin_out[P][B]        = here && drv_val[P][B];
      assign pin_oe_n_out[P][B]   = !drv_en[P][B];
      assign pull_up_en_out[P][B] = here && !pud_reg[P][B];
    end
  endgenerate

  assign pin_level_out = sync2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // External interrupt lines: F0..F7 are lines 0..7, G0..G15 are 8..23.

  logic [NL-1:0] line_level;
  logic [NL-1:0] line_en;
  logic [NL-1:0] line_event;

  genvar gl;
  generate
    for (gl = 0; gl < NL; gl++) begin : g_line
      localparam int P = (gl < gpmx_pkg::LINES_ON_F) ? gpmx_pkg::PORT_F : gpmx_pkg::PORT_G;
      localparam int B = (gl < gpmx_pkg::LINES_ON_F) ? gl : gl - gpmx_pkg::LINES_ON_F;
      localparam int T = gl / gpmx_pkg::LINES_PER_TRIG;
      localparam int F = (gl % gpmx_pkg::LINES_PER_TRIG) * gpmx_pkg::TRIG_FIELD_W;
      assign line_level[gl] = sync2_reg[P][B];
      assign line_en[gl]    = con_reg[P][2*B +: 2] == gpmx_pkg::FN_ALT1;
      gpmx_external_irq_line_filter u_filt (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .en_in    (line_en[gl]),
        .level_in (line_level[gl]),
        .mode_in  (trig_reg[T][F +: 3]),
        .event_out(line_event[gl])
      );
    end
  endgenerate

  // A new event in the cycle of its clear keeps the status bit set.
  assign stat_next = (stat_reg & ~(wr_clr ? wdata_in[NL-1:0] : '0)) | line_event;
  assign irq_out   = |(stat_reg & en_reg);
  // Wake needs the pins in interrupt function, which software must set first.
  assign wake_out  = |(stat_reg[gpmx_pkg::WAKE_LINES-1:0] &
                       en_reg[gpmx_pkg::WAKE_LINES-1:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Miscellaneous control outputs.

  assign misc_out.sleep_data_pud_dis = misc_reg[gpmx_pkg::MISC_SLEEP_PUD];
  assign misc_out.usb_pad_host       = misc_reg[gpmx_pkg::MISC_USB_PAD];
  assign misc_out.clock_output_pin_sel = misc_reg[gpmx_pkg::MISC_CLOCK_OUTPUT_PIN +: gpmx_pkg::CLKSEL_W];
  assign misc_out.clkout1_sel = misc_reg[gpmx_pkg::MISC_CLKOUT1 +: gpmx_pkg::CLKSEL_W];

  ////////////////////////////////////////////////////////////////////////////
  // Read mux.

  logic [31:0] port_word;
  logic [31:0] rd_mux;

  assign port_word = (sub_sel == gpmx_pkg::SUB_CON) ? con_reg[port_sel] :
                     (sub_sel == gpmx_pkg::SUB_DAT) ? {16'h0000, port_rd[port_sel]} :
                     (sub_sel == gpmx_pkg::SUB_PUD) ? {16'h0000, pud_reg[port_sel]} :
                                                      32'h0000_0000;
  assign rd_mux = port_hit                      ? port_word :
                  addr_in == gpmx_pkg::OFF_MISC  ? misc_reg :
                  addr_in == gpmx_pkg::OFF_TRIG0 ? trig_reg[0] :
                  addr_in == gpmx_pkg::OFF_TRIG1 ? trig_reg[1] :
                  addr_in == gpmx_pkg::OFF_TRIG2 ? trig_reg[2] :
                  addr_in == gpmx_pkg::OFF_STAT  ? {8'h00, stat_reg} :
                  addr_in == gpmx_pkg::OFF_EN    ? {8'h00, en_reg} :
                                                   32'h0000_0000;
  assign rdata_out = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Clocked state.

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_port
      assign wr_con[gp] = wr_in && port_hit && port_sel == 3'(gp) && sub_sel == gpmx_pkg::SUB_CON;
      assign wr_dat[gp] = wr_in && port_hit && port_sel == 3'(gp) && sub_sel == gpmx_pkg::SUB_DAT;
      assign wr_pud[gp] = wr_in && port_hit && port_sel == 3'(gp) && sub_sel == gpmx_pkg::SUB_PUD;
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          con_reg[gp] <= gpmx_pkg::CON_RST;
          dat_reg[gp] <= gpmx_pkg::DAT_RST;
          pud_reg[gp] <= gpmx_pkg::PUD_RST;
        end else begin
          if (wr_con[gp]) con_reg[gp] <= wdata_in;
          if (wr_dat[gp]) dat_reg[gp] <= wdata_in[PW-1:0] & gpmx_pkg::PIN_PRESENT[gp];
          if (wr_pud[gp]) pud_reg[gp] <= wdata_in[PW-1:0] & gpmx_pkg::PIN_PRESENT[gp];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    sync1_reg <= pin_in;
    sync2_reg <= sync1_reg;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      misc_reg  <= gpmx_pkg::MISC_RST;
      trig_reg  <= {3{gpmx_pkg::TRIG_RST}};
      stat_reg  <= '0;
      en_reg    <= gpmx_pkg::EN_RST;
      rdata_reg <= 32'h0000_0000;
    end else begin
      if (wr_misc) misc_reg <= wdata_in;
      for (int t = 0; t < 3; t++) begin
        if (wr_trig[t]) trig_reg[t] <= wdata_in;
      end
      stat_reg  <= stat_next;
      if (wr_en) en_reg <= wdata_in[NL-1:0];
      rdata_reg <= rd_in ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_out_drive: assert property (@(posedge clk_in) disable iff (rst_in)
    (out_mask & pin_oe_n_out) == '0 && ((pin_out ^ dat_reg) & out_mask) == '0)
    else $error("Output-mode pin does not drive its data bit.");

  a_in_readback: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_in && port_hit && sub_sel == gpmx_pkg::SUB_DAT |=>
      ((rdata_out[PW-1:0] ^ $past(sync2_reg[port_sel])) & $past(in_mask[port_sel])) == '0)
    else $error("Input pin level not returned on data read.");

  a_input_float: assert property (@(posedge clk_in) disable iff (rst_in)
    ((in_mask | rsv_mask) & ~pin_oe_n_out) == '0)
    else $error("Input or reserved-code pin is driven.");

  a_pull_write: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_in && port_hit && sub_sel == gpmx_pkg::SUB_PUD |=>
      pull_up_en_out[$past(port_sel)] ==
        (~$past(wdata_in[PW-1:0]) & gpmx_pkg::PIN_PRESENT[$past(port_sel)]))
    else $error("Pull-up enable does not follow the disable bits.");

  a_misc_clkout: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_misc |=> misc_out.clock_output_pin_sel ==
      $past(wdata_in[gpmx_pkg::MISC_CLOCK_OUTPUT_PIN +: gpmx_pkg::CLKSEL_W]))
    else $error("Clock-out select not taken from the write.");

  a_status_set_wins: assert property (@(posedge clk_in) disable iff (rst_in)
    (line_event != '0) |=> (stat_reg & $past(line_event)) == $past(line_event))
    else $error("Interrupt event lost against a clear.");

  a_irq_level: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(irq_out) |-> $past(stat_next & en_reg) != '0 || $past(wr_en))
    else $error("Interrupt raised with no enabled status.");

  a_wake_lines: assert property (@(posedge clk_in) disable iff (rst_in)
    (stat_reg[15:0] & en_reg[15:0]) != '0 |-> wake_out && irq_out)
    else $error("Enabled low line did not raise wake.");

  a_irq_pin_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
    (irq_alt_mask & ~pin_oe_n_out) == '0)
    else $error("Interrupt-function pin is driven.");

  a_line_gate: assert property (@(posedge clk_in) disable iff (rst_in)
    (line_event & ~line_en) == '0)
    else $error("Event on a line whose pin is not in interrupt function.");

  a_stat_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    !wr_clr |=> (stat_reg & $past(stat_reg)) == $past(stat_reg))
    else $error("Status bit dropped without a clear.");

  a_stat_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_clr |=> (stat_reg & $past(wdata_in[NL-1:0] & ~line_event)) == '0)
    else $error("Status bit survived its clear with no new event.");

  a_func_readback: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_in && port_hit && sub_sel == gpmx_pkg::SUB_CON |=>
      rdata_out == $past(con_reg[port_sel]))
    else $error("Function-select word not returned on read.");

  a_dat_write: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_in && port_hit && sub_sel == gpmx_pkg::SUB_DAT |=>
      dat_reg[$past(port_sel)] ==
        ($past(wdata_in[PW-1:0]) & gpmx_pkg::PIN_PRESENT[$past(port_sel)]))
    else $error("Data register did not take the write.");

  a_pull_func: assert property (@(posedge clk_in) disable iff (rst_in)
    pull_up_en_out == (~pud_reg & gpmx_pkg::PIN_PRESENT))
    else $error("Pull-up enable depends on more than its disable bit.");

endmodule // gpmx_top

`default_nettype wire

/* verification/gpmx_pin_model.sv */
// Behavioural model of the circuits that sit outside the port pins.
`timescale 1ns/1ps
`default_nettype none

module gpmx_pin_model (
  input  wire logic             clk_in,
  input  wire logic [4:0][15:0] drive_in,
  input  wire logic [4:0][15:0] oe_n_in,
  input  wire logic [4:0][15:0] pull_up_in,
  input  wire logic [4:0][15:0] ext_en_in,
  input  wire logic [4:0][15:0] ext_level_in,
  output logic      [4:0][15:0] level_out
);
  // A pin that nobody drives and that has no pull-up wanders from cycle to cycle.
  logic [4:0][15:0] float_reg = '0;

  always_ff @(posedge clk_in) begin
    float_reg <= ~float_reg;
  end

  // The device's own drive wins, then an outside driver, then the pull-up.
  assign level_out = (~oe_n_in & drive_in) | (oe_n_in & ext_en_in & ext_level_in)
                   | (oe_n_in & ~ext_en_in & (pull_up_in | float_reg));
endmodule // gpmx_pin_model
`default_nettype wire

/* verification/gpmx_top_tb.sv */
// Self-checking testbench for the pin mux and external interrupt block.
`timescale 1ns/1ps
`default_nettype none

module gpmx_top_tb;
  logic                          clk_in = 1'b0;
  logic                          rst_in;
  logic [7:0]                    addr_in;
  logic [31:0]                   wdata_in;
  logic                          wr_in;
  logic                          rd_in;
  logic [31:0]                   rdata_out;
  logic [4:0][15:0]              pin_in;
  logic [4:0][15:0]              pin_out;
  logic [4:0][15:0]              pin_oe_n_out;
  logic [4:0][15:0]              pull_up_en_out;
  gpmx_pkg::gpmx_drive_s [4:0]   alt1_in;
  gpmx_pkg::gpmx_drive_s [4:0]   alt2_in;
  logic [4:0][15:0]              pin_level_out;
  gpmx_pkg::gpmx_misc_s          misc_out;
  logic                          irq_out;
  logic                          wake_out;
  logic [4:0][15:0]              ext_en;
  logic [4:0][15:0]              ext_lvl;
  int                            n_errors = 0;
  int                            n_checks = 0;
  int                            cycles = 0;

  always #10 clk_in = ~clk_in;

  gpmx_top uut (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out), .pull_up_en_out(pull_up_en_out),
    .alt1_in(alt1_in), .alt2_in(alt2_in), .pin_level_out(pin_level_out),
    .misc_out(misc_out), .irq_out(irq_out), .wake_out(wake_out)
  );

  gpmx_pin_model pins (
    .clk_in(clk_in), .drive_in(pin_out), .oe_n_in(pin_oe_n_out),
    .pull_up_in(pull_up_en_out), .ext_en_in(ext_en), .ext_level_in(ext_lvl),
    .level_out(pin_in)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    @(negedge clk_in);
    chk(rdata_out, exp);
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("[ERR] %0t run did not finish", $time);
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_in = 1'b1;
    addr_in = 8'h00;
    wdata_in = 32'h0000_0000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    alt1_in = '0;
    alt2_in = '0;
    ext_en = '0;
    ext_lvl = '0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(8'h00, 32'h0000_0000);
    rd(8'h08, 32'h0000_0000);
    rd(8'h70, 32'h0000_0000);
    chk({16'h0000, pull_up_en_out[0]}, 32'h0000_FFFF);
    chk({16'h0000, pin_oe_n_out[0]}, 32'h0000_FFFF);
    // Port D: pin 0 output, pin 1 first alternate, pin 2 a refused code, pin 8 second.
    @(posedge clk_in);
    alt1_in[0] <= '{en: 16'hFFFF, level: 16'h0002};
    alt2_in[0] <= '{en: 16'hFFFF, level: 16'h0100};
    wr(8'h04, 32'h0000_0001);
    wr(8'h00, 32'h0003_0039);
    wr(8'h08, 32'h0000_0003);
    @(negedge clk_in);
    chk({30'h0, pin_out[0][1:0]}, 32'h0000_0003);
    chk({29'h0, pin_oe_n_out[0][2:0]}, 32'h0000_0004);
    chk({30'h0, pin_out[0][8], pin_oe_n_out[0][8]}, 32'h0000_0002);
    chk({16'h0000, pull_up_en_out[0]}, 32'h0000_FFFC);
    rd(8'h00, 32'h0003_0039);
    rd(8'h04, 32'h0000_FEF9);
    // Port J as plain inputs driven from outside.
    ext_en[4]  <= 16'hFFFF;
    ext_lvl[4] <= 16'h0A5A;
    repeat (4) @(posedge clk_in);
    rd(8'h44, 32'h0000_0A5A);
    chk({16'h0000, pin_level_out[4]}, 32'h0000_0A5A);
    wr(8'h50, 32'h0000_0539);
    rd(8'h50, 32'h0000_0539);
    chk({24'h00_0000, misc_out}, {24'h00_0000, 1'b1, 1'b1, 3'h3, 3'h5});
    // Lines 0 to 4 in low, high, falling, rising and both-edge modes; a peripheral
    // that asks to drive the port F interrupt pins must be ignored.
    @(posedge clk_in);
    ext_en[1]  <= 16'h001F;
    ext_lvl[1] <= 16'h0005;
    alt1_in[1] <= '{en: 16'hFFFF, level: 16'h0000};
    wr(8'h10, 32'h0000_AAAA);
    @(negedge clk_in);
    chk({16'h0000, pin_oe_n_out[1]}, 32'h0000_FFFF);
    wr(8'h54, 32'h0006_4210);
    wr(8'h68, 32'h00FF_FFFF);
    repeat (12) @(posedge clk_in);
    wr(8'h64, 32'h00FF_FFFF);
    rd(8'h60, 32'h0000_0000);
    @(posedge clk_in);
    ext_lvl[1] <= 16'h001A;
    repeat (3) @(posedge clk_in);
    ext_lvl[1] <= 16'h0005;
    repeat (12) @(posedge clk_in);
    rd(8'h60, 32'h0000_0000);
    ext_lvl[1] <= 16'h001A;
    repeat (12) @(posedge clk_in);
    rd(8'h60, 32'h0000_001F);
    chk({30'h0, irq_out, wake_out}, 32'h0000_0003);
    wr(8'h64, 32'h00FF_FFFF);
    rd(8'h60, 32'h0000_0003);
    ext_lvl[1] <= 16'h0005;
    repeat (12) @(posedge clk_in);
    rd(8'h60, 32'h0000_0013);
    rd(8'h64, 32'h0000_0000);
    wr(8'h68, 32'h0000_0000);
    @(negedge clk_in);
    chk({30'h0, irq_out, wake_out}, 32'h0000_0000);
    // Line 16 fires on its pulled-up pin but is no wakeup source.
    wr(8'h5C, 32'h0000_0001);
    wr(8'h20, 32'h0002_0000);
    wr(8'h64, 32'h00FF_FFFF);
    wr(8'h68, 32'h0001_0000);
    repeat (12) @(posedge clk_in);
    @(negedge clk_in);
    chk({30'h0, irq_out, wake_out}, 32'h0000_0002);
    complete_run();
  end
endmodule // gpmx_top_tb
`default_nettype wire
